// file: src/cca_pkg.sv
/*
 * constants for the five-module counter array capture/compare block:
 * register addresses, mode-register bit positions, reset values.
 * assumes an 8-bit register port, as the block's top module exposes.
 */
package cca_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_MODULES  = 5;
    localparam int WDT_MODULE   = 4;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 8;
    localparam int COUNT_W      = 16;

    typedef logic [DATA_W-1:0]  cca_byte_t;
    typedef logic [COUNT_W-1:0] cca_count_t;

    // ------------------------------------------------------------------
    // register addresses (module n sits at base + n)
    // ------------------------------------------------------------------
    localparam cca_byte_t ADDR_COUNTER_CONTROL = 8'hd8;
    localparam cca_byte_t ADDR_WDT_CONTROL     = 8'hd9;
    localparam cca_byte_t ADDR_MODE_BASE       = 8'hda;
    localparam cca_byte_t ADDR_COUNTER_LOW     = 8'he9;
    localparam cca_byte_t ADDR_CMP_LOW_BASE    = 8'hea;
    localparam cca_byte_t ADDR_COUNTER_HIGH    = 8'hf9;
    localparam cca_byte_t ADDR_CMP_HIGH_BASE   = 8'hfa;

    // ------------------------------------------------------------------
    // module mode register fields
    // ------------------------------------------------------------------
    localparam int MODE_COMPARE_EN  = 6;
    localparam int MODE_POS_CAPTURE = 5;
    localparam int MODE_NEG_CAPTURE = 4;
    localparam int MODE_MATCH_EN    = 3;
    localparam int MODE_TOGGLE_EN   = 2;
    localparam int MODE_PWM_EN      = 1;
    localparam int MODE_IRQ_EN      = 0;
    localparam cca_byte_t MODE_WRITE_MASK = 8'h7f;
    localparam cca_byte_t MODE_RESET      = 8'h00;

    // ------------------------------------------------------------------
    // counter control and watchdog control fields
    // ------------------------------------------------------------------
    localparam int CTRL_RUN        = 6;
    localparam int WDT_ENABLE_BIT  = 6;
    localparam cca_byte_t BYTE_ZERO     = 8'h00;
    localparam cca_byte_t LOW_BYTE_MAX  = 8'hff;
    localparam cca_count_t COUNT_ZERO   = 16'h0000;
    localparam cca_count_t COUNT_ONE    = 16'h0001;

endpackage

// file: src/cca_chan_if.sv
/*
 * per-module channel between the top and its compare unit:
 * counter, compare pair and mode in; match and width-modulation level out.
 * assumes both ends share the top's clock; no timing inside.
 */
`timescale 1ns/1ps
interface cca_chan_if;
    cca_pkg::cca_count_t count;
    cca_pkg::cca_count_t cmp_pair;
    cca_pkg::cca_byte_t  mode;
    logic                hit;
    logic                pwm_high;

    modport owner
    (
        output count,
        output cmp_pair,
        output mode,
        input  hit,
        input  pwm_high
    );
    modport unit
    (
        input  count,
        input  cmp_pair,
        input  mode,
        output hit,
        output pwm_high
    );
endinterface

// file: src/cca_pin_sync.sv
/*
 * two-flop synchroniser for the module pins plus edge detection.
 * assumes pins may change at any time relative to core_clk.
 */
`timescale 1ns/1ps
module cca_pin_sync #(
    parameter int WIDTH = 5
)(
    input  wire logic             core_clk,
    input  wire logic             rst_int_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] prev_reg;

    // --------------------------------------------------------------
    // synchroniser: meta_reg feeds only sync_reg
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign rise = sync_reg & ~prev_reg;
    assign fall = ~sync_reg & prev_reg;
endmodule // cca_pin_sync

// file: src/cca_cmp_unit.sv
/*
 * comparators of one module: 16-bit match and 8-bit width-modulation level.
 * assumes the owner qualifies the hit with the counter run state.
 */
`timescale 1ns/1ps
module cca_cmp_unit (
    cca_chan_if.unit chan
);
    // match only while compare enable is set
    assign chan.hit      = chan.mode[cca_pkg::MODE_COMPARE_EN] && (chan.count == chan.cmp_pair);
    // low below compare low byte gives a low output
    assign chan.pwm_high = (chan.count[cca_pkg::DATA_W-1:0] >= chan.cmp_pair[cca_pkg::DATA_W-1:0]);
endmodule // cca_cmp_unit

// file: src/cca_top.sv
/*
 * counter array with five capture/compare modules, register port,
 * width modulation and a module-four watchdog reset request.
 * assumes a single-cycle register master and pins asynchronous to core_clk.
 */
`timescale 1ns/1ps

module cca_top (
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    input  wire logic [4:0]               module_io_pin_in,
    output logic      [4:0]               module_io_pin_out,
    output logic      [4:0]               module_io_pin_oe,
    output logic                          irq_req,
    output logic                          internal_reset_req
);
    localparam int N = cca_pkg::NUM_MODULES;

    // ------------------------------------------------------------------
    // address decode helper
    // ------------------------------------------------------------------
    function automatic logic cca_sel(input logic [7:0] addr, input logic [7:0] base, input int idx);
        logic [7:0] target;
        target = base + 8'(idx);
        return addr == target;
    endfunction

    // ------------------------------------------------------------------
    // reset release synchroniser
    // ------------------------------------------------------------------
    logic [1:0] rst_pipe_reg;
    logic       rst_int_n;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe_reg <= 2'h0;
        else
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
    assign rst_int_n = rst_pipe_reg[1];

    // ------------------------------------------------------------------
    // shared counter and control
    // ------------------------------------------------------------------
    cca_pkg::cca_count_t count_reg;
    cca_pkg::cca_count_t count_next;
    logic [7:0]          ctrl_reg;
    logic [7:0]          ctrl_next;
    logic [7:0]          wdt_ctrl_reg;
    logic                run;
    logic                wr_ctrl;
    logic                wr_wdt;
    logic                wr_cnt_low;
    logic                wr_cnt_high;
    logic                low_wrap;
    logic [N-1:0]        event_set;

    assign run         = ctrl_reg[cca_pkg::CTRL_RUN];
    assign wr_ctrl     = reg_wr && (reg_addr == cca_pkg::ADDR_COUNTER_CONTROL);
    assign wr_wdt      = reg_wr && (reg_addr == cca_pkg::ADDR_WDT_CONTROL);
    assign wr_cnt_low  = reg_wr && (reg_addr == cca_pkg::ADDR_COUNTER_LOW);
    assign wr_cnt_high = reg_wr && (reg_addr == cca_pkg::ADDR_COUNTER_HIGH);
    // low byte is about to roll over on this tick
    assign low_wrap    = run && (count_reg[7:0] == cca_pkg::LOW_BYTE_MAX);

    always_comb
    begin
        count_next = run ? count_reg + cca_pkg::COUNT_ONE : count_reg;
        if (wr_cnt_low)
            count_next[7:0] = reg_wdata;
        if (wr_cnt_high)
            count_next[15:8] = reg_wdata;
    end

    // hardware set wins over a software clear in the same cycle
    always_comb
    begin
        ctrl_next = wr_ctrl ? reg_wdata : ctrl_reg;
        ctrl_next[N-1:0] = ctrl_next[N-1:0] | event_set;
    end

    always_ff @(posedge core_clk or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            count_reg    <= cca_pkg::COUNT_ZERO;
            ctrl_reg     <= cca_pkg::BYTE_ZERO;
            wdt_ctrl_reg <= cca_pkg::BYTE_ZERO;
        end
        else
        begin
            count_reg <= count_next;
            ctrl_reg  <= ctrl_next;
            if (wr_wdt)
                wdt_ctrl_reg <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    logic [N-1:0] pin_rise;
    logic [N-1:0] pin_fall;

    cca_pin_sync #(.WIDTH(N)) u_sync (
        .core_clk  (core_clk),
        .rst_int_n (rst_int_n),
        .pin_in    (module_io_pin_in),
        .rise      (pin_rise),
        .fall      (pin_fall)
    );

    // ------------------------------------------------------------------
    // capture/compare modules
    // ------------------------------------------------------------------
    cca_pkg::cca_byte_t mode_reg  [N];
    cca_pkg::cca_byte_t cmp_low_reg  [N];
    cca_pkg::cca_byte_t cmp_high_reg [N];
    logic [N-1:0]       hit_q;
    logic [N-1:0]       irq_terms;

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_mod
            cca_chan_if chan ();
            cca_pkg::cca_byte_t mode_next;
            logic wr_mode;
            logic wr_low;
            logic wr_high;
            logic capture;
            logic pwm_active;
            logic match_ev;
            logic toggle_ev;
            logic pin_reg;
            logic out_reg;

            assign chan.count    = count_reg;
            assign chan.cmp_pair = {cmp_high_reg[g], cmp_low_reg[g]};
            assign chan.mode     = mode_reg[g];

            cca_cmp_unit u_cmp (
                .chan (chan)
            );

            assign wr_mode = reg_wr && cca_sel(reg_addr, cca_pkg::ADDR_MODE_BASE, g);
            assign wr_low  = reg_wr && cca_sel(reg_addr, cca_pkg::ADDR_CMP_LOW_BASE, g);
            assign wr_high = reg_wr && cca_sel(reg_addr, cca_pkg::ADDR_CMP_HIGH_BASE, g);

            // either edge selection enables capture
            assign capture = (mode_reg[g][cca_pkg::MODE_POS_CAPTURE] && pin_rise[g])
                           || (mode_reg[g][cca_pkg::MODE_NEG_CAPTURE] && pin_fall[g]);
            assign pwm_active = mode_reg[g][cca_pkg::MODE_PWM_EN]
                              && mode_reg[g][cca_pkg::MODE_COMPARE_EN];
            // stopped counter would otherwise re-fire every cycle
            assign match_ev  = run && chan.hit && mode_reg[g][cca_pkg::MODE_MATCH_EN];
            assign toggle_ev = match_ev && mode_reg[g][cca_pkg::MODE_TOGGLE_EN] && !pwm_active;

            assign event_set[g] = capture || match_ev;
            assign irq_terms[g] = ctrl_reg[g] && mode_reg[g][cca_pkg::MODE_IRQ_EN];
            assign hit_q[g]     = match_ev;

            // bus write on the mode register wins over compare-byte side effects
            always_comb
            begin
                mode_next = mode_reg[g];
                if (wr_low)
                    mode_next[cca_pkg::MODE_COMPARE_EN] = 1'b0;
                if (wr_high)
                    mode_next[cca_pkg::MODE_COMPARE_EN] = 1'b1;
                if (wr_mode)
                    mode_next = reg_wdata & cca_pkg::MODE_WRITE_MASK;
            end

            always_ff @(posedge core_clk or negedge rst_int_n)
            begin
                if (!rst_int_n)
                begin
                    mode_reg[g]     <= cca_pkg::MODE_RESET;
                    cmp_low_reg[g]  <= cca_pkg::BYTE_ZERO;
                    cmp_high_reg[g] <= cca_pkg::BYTE_ZERO;
                    pin_reg         <= 1'b0;
                    out_reg         <= 1'b0;
                end
                else
                begin
                    mode_reg[g] <= mode_next;
                    // capture beats reload beats a bus write to the low byte
                    if (capture)
                    begin
                        cmp_low_reg[g]  <= count_reg[7:0];
                        cmp_high_reg[g] <= count_reg[15:8];
                    end
                    else
                    begin
                        if (pwm_active && low_wrap)
                            cmp_low_reg[g] <= cmp_high_reg[g];
                        else if (wr_low)
                            cmp_low_reg[g] <= reg_wdata;
                        if (wr_high)
                            cmp_high_reg[g] <= reg_wdata;
                    end
                    if (toggle_ev)
                        pin_reg <= ~pin_reg;
                    out_reg <= pwm_active ? chan.pwm_high : (toggle_ev ? ~pin_reg : pin_reg);
                end
            end

            assign module_io_pin_out[g] = out_reg;
            // pin is driven only in toggle or width-modulation use
            assign module_io_pin_oe[g]  = pwm_active
                                        || (mode_reg[g][cca_pkg::MODE_COMPARE_EN]
                                            && mode_reg[g][cca_pkg::MODE_TOGGLE_EN]);
        end
    endgenerate

    assign irq_req = |irq_terms;

    // ------------------------------------------------------------------
    // watchdog on module four
    // ------------------------------------------------------------------
    logic wdt_fire;
    logic wdt_reg;

    // module four keeps all normal modes; the reset is an extra consumer
    assign wdt_fire = wdt_ctrl_reg[cca_pkg::WDT_ENABLE_BIT] && hit_q[cca_pkg::WDT_MODULE];

    always_ff @(posedge core_clk or negedge rst_int_n)
    begin
        if (!rst_int_n)
            wdt_reg <= 1'b0;
        else
            wdt_reg <= wdt_fire;
    end
    // internal request only; no external reset pin is driven
    assign internal_reset_req = wdt_reg;

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    cca_pkg::cca_byte_t rd_mux;
    cca_pkg::cca_byte_t rdata_reg;

    always_comb
    begin
        rd_mux = cca_pkg::BYTE_ZERO;
        if (reg_addr == cca_pkg::ADDR_COUNTER_CONTROL)
            rd_mux = ctrl_reg;
        if (reg_addr == cca_pkg::ADDR_WDT_CONTROL)
            rd_mux = wdt_ctrl_reg;
        if (reg_addr == cca_pkg::ADDR_COUNTER_LOW)
            rd_mux = count_reg[7:0];
        if (reg_addr == cca_pkg::ADDR_COUNTER_HIGH)
            rd_mux = count_reg[15:8];
        for (int i = 0; i < N; i++)
        begin
            if (cca_sel(reg_addr, cca_pkg::ADDR_MODE_BASE, i))
                rd_mux = mode_reg[i];
            if (cca_sel(reg_addr, cca_pkg::ADDR_CMP_LOW_BASE, i))
                rd_mux = cmp_low_reg[i];
            if (cca_sel(reg_addr, cca_pkg::ADDR_CMP_HIGH_BASE, i))
                rd_mux = cmp_high_reg[i];
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n)
    begin
        if (!rst_int_n)
            rdata_reg <= cca_pkg::BYTE_ZERO;
        else
            rdata_reg <= reg_rd ? rd_mux : cca_pkg::BYTE_ZERO;
    end
    assign reg_rdata = rdata_reg;
endmodule // cca_top

// file: tb/cca_pin_partner.sv
/*
 * outside world on the five module pins: a slow, skewed level source.
 * assumes the bench asks for levels; the block's driver wins where enabled.
 */
`timescale 1ns/1ps
module cca_pin_partner #(
    parameter int SKEW_NS = 37
)(
    input  wire logic [4:0] level_req,
    input  wire logic [4:0] oe,
    input  wire logic [4:0] dut_out,
    output logic      [4:0] pin
);
    // ------------------------------------------------------------------
    // skewed source and shared wire
    // ------------------------------------------------------------------
    logic [4:0] ext_level = 5'h00;

    // skew keeps edges away from core_clk, so the synchroniser earns its keep
    always @(level_req) ext_level <= #(SKEW_NS) level_req;
    assign pin = (oe & dut_out) | (~oe & ext_level);
endmodule // cca_pin_partner

// file: tb/cca_top_assertions.sv
/*
 * checker for cca_top: read timing, mode shadow, interrupt gating,
 * pin enables and watchdog pulses.
 * assumes it is bound to cca_top and sees only its ports.
 */
`timescale 1ns/1ps
module cca_top_chk (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] module_io_pin_in,
    input wire logic [4:0] module_io_pin_out,
    input wire logic [4:0] module_io_pin_oe,
    input wire logic       irq_req,
    input wire logic       internal_reset_req
);
    // ------------------------------------------------------------------
    // shadow of mode and watchdog enables
    // ------------------------------------------------------------------
    logic [4:0][7:0] mode_reg;
    logic            wdt_en_reg;
    logic [4:0]      irq_en;
    logic [4:0]      idle_mask;
    logic [7:0]      mode_off;
    logic [7:0]      mode_val;
    logic            mode_hit;
    logic            wdt_armed;

    assign mode_off  = reg_addr - cca_pkg::ADDR_MODE_BASE;
    assign mode_hit  = mode_off < 8'h05;
    assign mode_val  = mode_reg[mode_off[2:0]];
    assign wdt_armed = wdt_en_reg & mode_reg[4][6] & mode_reg[4][3];

    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            irq_en[i]    = mode_reg[i][0];
            idle_mask[i] = mode_reg[i] == 8'h00;
        end
    end

    // compare bytes sit 0x10 and 0x20 above the mode registers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg   <= '0;
            wdt_en_reg <= 1'b0;
        end
        else if (reg_wr && mode_hit)
            mode_reg[mode_off[2:0]] <= reg_wdata & 8'h7f;
        else if (reg_wr && (mode_off - 8'h10) < 8'h05)
            mode_reg[mode_off[2:0] - 3'h0][6] <= 1'b0;
        else if (reg_wr && (mode_off - 8'h20) < 8'h05)
            mode_reg[mode_off[2:0]][6] <= 1'b1;
        else if (reg_wr && reg_addr == cca_pkg::ADDR_WDT_CONTROL)
            wdt_en_reg <= reg_wdata[6];
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside its cycle");
    chk_mode_readback: assert property (reg_rd && mode_hit ##1 1'b1 |-> reg_rdata == $past(mode_val))
        else $error("mode register read differs from shadow");
    chk_reserved_bit: assert property (reg_rd && mode_hit |=> !reg_rdata[7])
        else $error("reserved mode bit reads one");
    chk_rdata_unmapped: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_irq_gated: assert property (irq_req |-> (irq_en != 5'h00))
        else $error("interrupt without any enable");
    chk_oe_idle: assert property ((module_io_pin_oe & idle_mask) == 5'h00)
        else $error("idle module drives its pin");
    chk_wdt_pulse: assert property (internal_reset_req |=> !internal_reset_req)
        else $error("watchdog request longer than one cycle");
    chk_wdt_armed: assert property (internal_reset_req |-> $past(wdt_armed))
        else $error("watchdog request while not armed");

    cover property (internal_reset_req);
    cover property (irq_req);
    cover property (reg_rd && mode_hit);
endmodule // cca_top_chk

bind cca_top cca_top_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .module_io_pin_in(module_io_pin_in), .module_io_pin_out(module_io_pin_out),
    .module_io_pin_oe(module_io_pin_oe), .irq_req(irq_req), .internal_reset_req(internal_reset_req));

// file: tb/tb_top.sv
/*
 * self-checking bench for cca_top: registers, capture, match, toggle,
 * width modulation and watchdog, with a partner on the module pins.
 * assumes the checker binds itself from its own file.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin tests_run++; if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    localparam logic [7:0] MB = cca_pkg::ADDR_MODE_BASE;
    localparam logic [7:0] LB = cca_pkg::ADDR_CMP_LOW_BASE;
    localparam logic [7:0] HB = cca_pkg::ADDR_CMP_HIGH_BASE;
    localparam logic [7:0] CTL = cca_pkg::ADDR_COUNTER_CONTROL;
    localparam logic [4:0][7:0] CAPM = {8'h11, 8'h20, 8'h31, 8'h10, 8'h21};
    logic        core_clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [4:0]  pin_in;
    logic [4:0]  pin_out;
    logic [4:0]  pin_oe;
    logic        irq_req;
    logic        wdt_req;
    logic [4:0]  ext_level;
    logic [7:0]  v;
    logic [7:0]  md;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [1:0]  p;
    int          err_count;
    int          tests_run;
    int          wdt_pulses = 0;
    int          wdt_base;
    int          seed;

    cca_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .module_io_pin_in(pin_in),
        .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe), .irq_req(irq_req),
        .internal_reset_req(wdt_req));
    cca_pin_partner peer (.level_req(ext_level), .oe(pin_oe), .dut_out(pin_out), .pin(pin_in));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
        if (wdt_req === 1'b1)
            wdt_pulses++;

    // ------------------------------------------------------------------
    // expectations, bus cycles, verdict
    // ------------------------------------------------------------------
    function automatic logic edge_hit(input logic [7:0] mode, input logic rising);
        return rising ? mode[cca_pkg::MODE_POS_CAPTURE] : mode[cca_pkg::MODE_NEG_CAPTURE];
    endfunction

    function automatic logic pwm_lvl(input logic [7:0] low_byte, input logic [7:0] cmp);
        return low_byte >= cmp;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] ex);
        logic [7:0] got;
        rd(a, got);
        `CHK(nm, ex, got)
    endtask

    // counter is stopped first so the loaded value holds
    task automatic set_cnt(input logic [15:0] c);
        wr(CTL, 8'h00);
        wr(cca_pkg::ADDR_COUNTER_LOW, c[7:0]);
        wr(cca_pkg::ADDR_COUNTER_HIGH, c[15:8]);
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic give_verdict();
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #2000000;
        err_count++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        seed = 32'h1807;
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ext_level = 5'h00;
        err_count = 0;
        tests_run = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_cycles(3);
        rdc("unmapped read", 8'h00, 8'h00);
        for (int n = 0; n < 5; n++)
        begin
            rdc("mode reset", MB + 8'(n), 8'h00);
            md = 8'($random(seed)) & 8'h7d;
            wr(MB + 8'(n), md | 8'h80);
            rdc("mode readback", MB + 8'(n), md);
            wr(LB + 8'(n), 8'h5a);
            rdc("mode after low", MB + 8'(n), md & 8'h3d);
            wr(HB + 8'(n), 8'ha5);
            rdc("mode after high", MB + 8'(n), md | 8'h40);
            wr(MB + 8'(n), md & 8'h3d);
            rdc("mode direct", MB + 8'(n), md & 8'h3d);
            wr(MB + 8'(n), CAPM[n]);
            cap = 16'ha55a;
            for (int e = 1; e >= 0; e--)
            begin
                cnt = 16'($random(seed));
                set_cnt(cnt);
                ext_level[n] <= e[0];
                wait_cycles(8);
                if (edge_hit(CAPM[n], e[0]))
                    cap = cnt;
                rd(CTL, v);
                `CHK("capture flag", edge_hit(CAPM[n], e[0]), v[n])
                `CHK("interrupt", edge_hit(CAPM[n], e[0]) & CAPM[n][0], irq_req)
                rdc("capture low", LB + 8'(n), cap[7:0]);
                rdc("capture high", HB + 8'(n), cap[15:8]);
            end
        end
        cnt = 16'($random(seed)) | 16'h0100;
        set_cnt(cnt - 16'h0006);
        for (int n = 1; n < 3; n++)
        begin
            wr(LB + 8'(n), cnt[7:0]);
            wr(HB + 8'(n), cnt[15:8]);
        end
        wr(MB + 8'h01, 8'h4c);
        wr(MB + 8'h02, 8'h44);
        p = pin_out[2:1];
        wr(CTL, 8'h40);
        wait_cycles(20);
        rd(CTL, v);
        `CHK("match flags", 2'b01, v[2:1])
        `CHK("toggle", {p[1], ~p[0]}, pin_out[2:1])
        set_cnt(16'h0000);
        wr(LB + 8'h03, 8'h80);
        wr(HB + 8'h03, 8'h30);
        wr(MB + 8'h03, 8'h42);
        wr(MB + 8'h00, 8'h02);
        for (int ph = 0; ph < 2; ph++)
        begin
            wr(CTL, 8'h40);
            wait_cycles(ph * 280 + 20 + ($random(seed) & 63));
            wr(CTL, 8'h00);
            rd(cca_pkg::ADDR_COUNTER_LOW, v);
            md = ph ? 8'h30 : 8'h80;
            `CHK("pwm level", pwm_lvl(v, md), pin_out[3])
            `CHK("pwm without compare", 1'b0, pin_out[0])
            `CHK("pwm drive", 2'b10, {pin_oe[3], pin_oe[0]})
            rdc("pwm reload", LB + 8'h03, md);
        end
        cnt = 16'($random(seed)) | 16'h0100;
        wr(LB + 8'h04, cnt[7:0]);
        wr(HB + 8'h04, cnt[15:8]);
        wr(MB + 8'h04, 8'h48);
        for (int w = 0; w < 2; w++)
        begin
            set_cnt(cnt - 16'h0008);
            wr(cca_pkg::ADDR_WDT_CONTROL, w ? 8'h40 : 8'h00);
            wdt_base = wdt_pulses;
            wr(CTL, 8'h40);
            wait_cycles(20);
            rd(CTL, v);
            `CHK("module four flag", 1'b1, v[4])
            `CHK("watchdog pulses", w, wdt_pulses - wdt_base)
        end
        wr(cca_pkg::ADDR_WDT_CONTROL, 8'h00);
        give_verdict();
    end
endmodule // tb_top
